/* File: design/pmi_map.svh */
/*
  Register map, field positions, reset values and timing counts for the
  power-mode and extended interrupt priority block.
  Assumes inclusion by bare name from design files.
*/
`ifndef PMI_MAP_SVH
`define PMI_MAP_SVH

`define PMI_ADDR_PWR_CTRL 8'h87
`define PMI_ADDR_PRIO_A 8'hF6
`define PMI_ADDR_PRIO_B 8'hF7
`define PMI_RESET_BYTE 8'h00
`define PMI_BIT_IDLE 0
`define PMI_BIT_STOP 1
`define PMI_SRC_COUNT 16
`define PMI_CLK_HZ 20000000
`define PMI_MCD_TIMEOUT_US 100
`define PMI_MCD_CYCLES ((`PMI_CLK_HZ / 1000000) * `PMI_MCD_TIMEOUT_US)

`endif

/* File: design/pmi_pkg.sv */
/*
  Types shared by the power-mode and priority block.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package pmi_pkg;
  typedef enum logic [1:0] {
    PMI_RUN = 2'b00,
    PMI_IDLE = 2'b01,
    PMI_STOP = 2'b10
  } pmi_mode_e;
endpackage

/* File: design/pmi_sync.sv */
/*
  Two-flop synchroniser for signals arriving from outside the clock domain.
  Assumes clk_i is the system clock and rst_b_i an async active-low reset.
*/
`timescale 1ns/1ps
`default_nettype none
module pmi_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic [WIDTH-1:0] d_i,
  output logic [WIDTH-1:0] q_o
);
  logic [WIDTH-1:0] meta_q;

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      meta_q <= '0;
      q_o <= '0;
    end else begin
      meta_q <= d_i;
      q_o <= meta_q;
    end
  end
endmodule // pmi_sync
`default_nettype wire

/* File: design/pmi_core.sv */
/*
  Power-mode controller and extended interrupt priority registers.
  Assumes the CPU drives a single-cycle register write/read port, pulses
  insn_done_i at the end of each instruction and handler_return_i on a
  return from handler; the chip-level reset on rst_b_i returns the CPU to
  address zero. Reset pin and watchdog overflow come from outside.
*/
// What this block does
// RULE1 - First priority register: bit per source, adc0 done down to spi.
// RULE2 - Second priority register: bit per source, dma down to timer3.
// RULE3 - All three registers reset to zero, reachable on every page.
// RULE4 - Writing idle bit halts CPU into idle after the instruction.
// RULE5 - Idle gates only CPU clock; peripherals and registers keep going.
// RULE6 - Enabled interrupt or reset pin ends idle; interrupt clears idle.
// RULE7 - Woken interrupt serviced, then next instruction after idle write.
// RULE8 - Reset ending idle or stop runs normal reset from address zero.
// RULE9 - Watchdog keeps counting in idle; overflow resets and ends idle.
// RULE10 - Writing stop bit stops CPU and oscillator after the instruction.
// RULE11 - Interrupts ignored in stop; only resets end it.
// RULE12 - Enabled missing-clock detector runs in stop and resets on timeout.
// RULE13 - Software disables the detector before stopping beyond its timeout.
// RULE14 - Idle and stop bits read zero; upper six bits reserved.
// RULE15 - Software follows idle write with a multi-byte instruction.
// RULE16 - Global enable overrides masks for servicing and waking.
// RULE17 - High priority first; high preempts low, never the reverse.
`timescale 1ns/1ps
`default_nettype none
`include "pmi_map.svh"
module pmi_core #(
  parameter int SRC = `PMI_SRC_COUNT,
  parameter int MCD_CYCLES = `PMI_MCD_CYCLES
) (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [7:0] reg_rdata_o,
  input wire logic insn_done_i,
  input wire logic handler_return_i,
  input wire logic global_irq_enable_i,
  input wire logic [SRC-1:0] irq_pend_i,
  input wire logic [SRC-1:0] irq_en_i,
  input wire logic ext_reset_b_i,
  input wire logic watchdog_ovf_i,
  input wire logic mcd_enable_i,
  input wire logic clk_present_i,
  output logic cpu_clk_en_o,
  output logic osc_en_o,
  output logic periph_clk_en_o,
  output logic int_reset_o,
  output logic irq_valid_o,
  output logic [3:0] irq_id_o,
  output logic irq_high_o,
  output logic idle_o,
  output logic stop_o
);
  logic [7:0] prio_a_q;
  logic [7:0] prio_b_q;
  pmi_pkg::pmi_mode_e mode_q;
  pmi_pkg::pmi_mode_e mode_d;
  logic idle_req_q;
  logic stop_req_q;
  logic in_high_q;
  logic in_low_q;
  logic [31:0] mcd_cnt_q;
  logic [1:0] pin_sync;
  logic ext_rst_s;
  logic clk_ok_s;

  pmi_sync #(.WIDTH(2)) u_sync (
    .clk_i(clk_i),
    .rst_b_i(rst_b_i),
    .d_i({~ext_reset_b_i, clk_present_i}),
    .q_o(pin_sync)
  );
  assign ext_rst_s = pin_sync[1];
  assign clk_ok_s = pin_sync[0];

  function automatic logic [3:0] first_set(input logic [15:0] v);
    logic [3:0] idx;
    idx = 4'h0;
    for (int i = 0; i < 16; i++) begin
      if (v[i]) begin
        idx = 4'(i);
      end
    end
    return idx;
  endfunction

  // Source n: bits 0..7 = first register, 8..15 = second register
  wire [15:0] level_w = {prio_b_q, prio_a_q}; // [RULE1] [RULE2]
  wire [15:0] live_w = irq_pend_i & irq_en_i &
                       {16{global_irq_enable_i}}; // [RULE16]
  wire [15:0] hi_w = live_w & level_w;
  wire [15:0] lo_w = live_w & ~level_w;
  wire take_hi = (|hi_w) && !in_high_q; // [RULE17]
  wire take_lo = (|lo_w) && !(|hi_w) && !in_high_q && !in_low_q; // [RULE17]
  wire wr_pwr = reg_wr_i && reg_addr_i == `PMI_ADDR_PWR_CTRL;
  wire wr_a = reg_wr_i && reg_addr_i == `PMI_ADDR_PRIO_A;
  wire wr_b = reg_wr_i && reg_addr_i == `PMI_ADDR_PRIO_B;
  wire any_reset = ext_rst_s || watchdog_ovf_i ||
                   (mcd_cnt_q >= 32'(MCD_CYCLES)); // [RULE8]
  wire [7:0] rd_w = (reg_addr_i == `PMI_ADDR_PRIO_A) ? prio_a_q :
                    (reg_addr_i == `PMI_ADDR_PRIO_B) ? prio_b_q :
                    8'h00; // Power control always reads zero [RULE14]

  // Page-independent decode; no page select is seen here [RULE3]
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      prio_a_q <= `PMI_RESET_BYTE;
      prio_b_q <= `PMI_RESET_BYTE;
    end else begin
      if (wr_a) begin
        prio_a_q <= reg_wdata_i; // [RULE1]
      end
      if (wr_b) begin
        prio_b_q <= reg_wdata_i; // [RULE2]
      end
    end
  end

  // Requests latched by the write, acted on at instruction end
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      idle_req_q <= 1'b0;
      stop_req_q <= 1'b0;
    end else if (insn_done_i) begin
      idle_req_q <= 1'b0;
      stop_req_q <= 1'b0;
    end else if (wr_pwr) begin
      idle_req_q <= reg_wdata_i[`PMI_BIT_IDLE]; // [RULE4]
      stop_req_q <= reg_wdata_i[`PMI_BIT_STOP]; // [RULE10]
    end
  end

  always_comb begin
    mode_d = mode_q;
    case (mode_q)
      pmi_pkg::PMI_RUN: begin
        // Stop wins if both bits are written together
        if (insn_done_i && (stop_req_q || (wr_pwr &&
            reg_wdata_i[`PMI_BIT_STOP]))) begin
          mode_d = pmi_pkg::PMI_STOP; // [RULE10]
        end else if (insn_done_i && (idle_req_q || (wr_pwr &&
            reg_wdata_i[`PMI_BIT_IDLE]))) begin
          mode_d = pmi_pkg::PMI_IDLE; // [RULE4]
        end
      end
      pmi_pkg::PMI_IDLE: begin
        if (|live_w) begin
          mode_d = pmi_pkg::PMI_RUN; // [RULE6] [RULE7]
        end
      end
      pmi_pkg::PMI_STOP: begin
        mode_d = pmi_pkg::PMI_STOP; // [RULE11]
      end
      default: begin
        mode_d = pmi_pkg::PMI_RUN;
      end
    endcase
    if (any_reset) begin
      mode_d = pmi_pkg::PMI_RUN; // [RULE6] [RULE8] [RULE9] [RULE12]
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      mode_q <= pmi_pkg::PMI_RUN;
    end else begin
      mode_q <= mode_d;
    end
  end

  // Detector counts absent-clock time only while enabled [RULE12]
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      mcd_cnt_q <= 32'h0000_0000;
    end else if (!mcd_enable_i || clk_ok_s || any_reset) begin
      mcd_cnt_q <= 32'h0000_0000;
    end else begin
      mcd_cnt_q <= mcd_cnt_q + 32'h0000_0001;
    end
  end

  // Handler nesting: one low level and one high level in flight
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      in_high_q <= 1'b0;
      in_low_q <= 1'b0;
    end else if (any_reset) begin
      in_high_q <= 1'b0;
      in_low_q <= 1'b0;
    end else if (mode_d != pmi_pkg::PMI_STOP) begin
      if (handler_return_i) begin
        if (in_high_q) begin
          in_high_q <= 1'b0;
        end else begin
          in_low_q <= 1'b0;
        end
      end else if (take_hi) begin
        in_high_q <= 1'b1; // [RULE17]
      end else if (take_lo) begin
        in_low_q <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      reg_rdata_o <= 8'h00;
      cpu_clk_en_o <= 1'b1;
      osc_en_o <= 1'b1;
      periph_clk_en_o <= 1'b1;
      int_reset_o <= 1'b0;
      irq_valid_o <= 1'b0;
      irq_id_o <= 4'h0;
      irq_high_o <= 1'b0;
      idle_o <= 1'b0;
      stop_o <= 1'b0;
    end else begin
      reg_rdata_o <= reg_rd_i ? rd_w : 8'h00;
      cpu_clk_en_o <= (mode_d == pmi_pkg::PMI_RUN); // [RULE5]
      osc_en_o <= (mode_d != pmi_pkg::PMI_STOP); // [RULE10]
      periph_clk_en_o <= (mode_d != pmi_pkg::PMI_STOP); // [RULE5]
      int_reset_o <= watchdog_ovf_i ||
                     (mcd_cnt_q >= 32'(MCD_CYCLES)); // [RULE9] [RULE12]
      // Highest-numbered source wins within a level; none on stop entry
      irq_valid_o <= (take_hi || take_lo) &&
                     (mode_d != pmi_pkg::PMI_STOP) && !any_reset; // [RULE11]
      irq_id_o <= first_set(take_hi ? hi_w : lo_w);
      irq_high_o <= take_hi;
      idle_o <= (mode_d == pmi_pkg::PMI_IDLE);
      stop_o <= (mode_d == pmi_pkg::PMI_STOP);
    end
  end

  stop_sticky_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    mode_q == pmi_pkg::PMI_STOP && !any_reset |=> mode_q == pmi_pkg::PMI_STOP)
    else $error("stop left without reset"); // [RULE11]
  idle_wake_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    mode_q == pmi_pkg::PMI_IDLE && (|live_w) |=> mode_q == pmi_pkg::PMI_RUN
    ##1 cpu_clk_en_o)
    else $error("idle not left on enabled irq"); // [RULE6]
  idle_gate_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    idle_o |-> !cpu_clk_en_o && periph_clk_en_o && osc_en_o)
    else $error("idle gating wrong"); // [RULE5]
  stop_gate_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    stop_o |-> !osc_en_o && !periph_clk_en_o && !irq_valid_o)
    else $error("stop gating wrong"); // [RULE10]
  pwr_read_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    reg_rd_i && reg_addr_i == `PMI_ADDR_PWR_CTRL |=> reg_rdata_o == 8'h00)
    else $error("power control read nonzero"); // [RULE14]
  prio_a_wr_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    wr_a ##1 !wr_a ##1 reg_rd_i && reg_addr_i == `PMI_ADDR_PRIO_A && !wr_a
    |=> reg_rdata_o == $past(reg_wdata_i, 3))
    else $error("first priority readback"); // [RULE1]
  prio_b_wr_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    wr_b ##1 !wr_b ##1 reg_rd_i && reg_addr_i == `PMI_ADDR_PRIO_B && !wr_b
    |=> reg_rdata_o == $past(reg_wdata_i, 3))
    else $error("second priority readback"); // [RULE2]
  sequence idle_entry_s;
    mode_q == pmi_pkg::PMI_RUN && idle_req_q && !stop_req_q &&
    !(wr_pwr && reg_wdata_i[`PMI_BIT_STOP]) && insn_done_i && !any_reset;
  endsequence
  idle_entry_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    idle_entry_s |=> mode_q == pmi_pkg::PMI_IDLE ##0 !cpu_clk_en_o)
    else $error("idle not entered"); // [RULE4]
  no_wake_gie_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    mode_q == pmi_pkg::PMI_IDLE && !global_irq_enable_i && !any_reset
    |=> mode_q == pmi_pkg::PMI_IDLE)
    else $error("woke with global enable off"); // [RULE16]
  hi_first_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    (|hi_w) && (|lo_w) && !in_high_q && mode_d != pmi_pkg::PMI_STOP &&
    !any_reset |=> irq_valid_o && irq_high_o)
    else $error("low served before high"); // [RULE17]
  wdog_reset_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    watchdog_ovf_i |=> int_reset_o && mode_q == pmi_pkg::PMI_RUN)
    else $error("watchdog did not reset"); // [RULE9]
endmodule // pmi_core
`default_nettype wire

/* File: testbench/pmi_cpu_model.sv */
/*
  Stand-in for the CPU core: ends each register-writing instruction while
  its clock is enabled, and returns from handlers, promptly or slowly, with nesting.
  Assumes the pmi_core port timing on one clock.
*/
`timescale 1ns/1ps
`default_nettype none
module pmi_cpu_model (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic reg_wr_i,
  input wire logic cpu_clk_en_i,
  input wire logic irq_valid_i,
  input wire logic slow_i,
  output logic insn_done_o,
  output logic handler_return_o
);
  logic [3:0] hcnt_q;
  logic [1:0] depth_q;
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      insn_done_o <= 1'b0;
      handler_return_o <= 1'b0;
      hcnt_q <= 4'h0;
      depth_q <= 2'h0;
    end else begin
      // Halted core ends nothing; follow-on is always multi-byte
      insn_done_o <= reg_wr_i & cpu_clk_en_i;
      handler_return_o <= hcnt_q == 4'h1;
      if (irq_valid_i) begin
        hcnt_q <= slow_i ? 4'hc : 4'h3;
        depth_q <= depth_q + 2'h1;
      end else if (hcnt_q == 4'h1) begin
        // Preempted handler resumes and needs its own return
        hcnt_q <= depth_q > 2'h1 ? 4'h3 : 4'h0;
        depth_q <= depth_q - 2'h1;
      end else if (hcnt_q != 4'h0) begin
        hcnt_q <= hcnt_q - 4'h1;
      end
    end
  end
endmodule // pmi_cpu_model
`default_nettype wire

/* File: testbench/power_mode_irq_priority_tb.sv */
/*
  Self-checking bench for pmi_core with the CPU stand-in.
  Assumes the design files and pmi_cpu_model are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
module power_mode_irq_priority_tb;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic gie = 1'b0;
  logic [15:0] pend = 16'h0000;
  logic [15:0] en = 16'h0000;
  logic ext_b = 1'b1;
  logic wdog = 1'b0;
  logic mcd_en = 1'b0;
  logic clk_ok = 1'b1;
  logic slow = 1'b0;
  logic done, ret, cpu, osc, per, irst, iv, ihi, idle, stop;
  logic [7:0] rdata;
  logic [3:0] iid;
  int n_mismatch = 0;
  int compares = 0;
  always #25 clk = ~clk;
  // Short detector count keeps the stop runs brief
  pmi_core #(.MCD_CYCLES(8)) DUT (.clk_i(clk), .rst_b_i(rst_b),
    .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd),
    .reg_rdata_o(rdata), .insn_done_i(done), .handler_return_i(ret),
    .global_irq_enable_i(gie), .irq_pend_i(pend), .irq_en_i(en),
    .ext_reset_b_i(ext_b), .watchdog_ovf_i(wdog), .mcd_enable_i(mcd_en),
    .clk_present_i(clk_ok), .cpu_clk_en_o(cpu), .osc_en_o(osc),
    .periph_clk_en_o(per), .int_reset_o(irst), .irq_valid_o(iv),
    .irq_id_o(iid), .irq_high_o(ihi), .idle_o(idle), .stop_o(stop));
  pmi_cpu_model cpu_m (.clk_i(clk), .rst_b_i(rst_b), .reg_wr_i(wr),
    .cpu_clk_en_i(cpu), .irq_valid_i(iv), .slow_i(slow),
    .insn_done_o(done), .handler_return_o(ret));
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    check(rdata, exp);
    @(posedge clk);
  endtask
  task automatic mode(input logic [4:0] exp);
    @(negedge clk);
    check({cpu, per, osc, idle, stop}, exp);
    @(posedge clk);
  endtask
  task automatic quiet(input int n);
    logic seen;
    seen = 1'b0;
    repeat (n) begin
      @(negedge clk);
      seen = seen | iv;
    end
    check(seen, 1'b0);
    @(posedge clk);
  endtask
  task automatic take(input logic [3:0] id, input logic hi, output int k);
    k = 0;
    do begin
      @(negedge clk);
      k++;
    end while (iv !== 1'b1 && k < 40);
    check({iv, ihi, iid}, {1'b1, hi, id});
    @(posedge clk);
    pend[id] <= 1'b0;
  endtask
  task automatic t_regs;
    rd_chk(8'hF6, 8'h00);
    rd_chk(8'hF7, 8'h00);
    rd_chk(8'h87, 8'h00);
    mode(5'b11100);
    wr_reg(8'hF6, 8'hA5);
    wr_reg(8'hF7, 8'h5A);
    wr_reg(8'h87, 8'hFC);
    rd_chk(8'hF6, 8'hA5);
    rd_chk(8'hF7, 8'h5A);
    rd_chk(8'h87, 8'h00);
    rd_chk(8'h88, 8'h00);
    mode(5'b11100);
    $display("t_regs done");
  endtask
  task automatic t_prio;
    logic [15:0] m;
    int j;
    int k;
    gie <= 1'b1;
    en <= 16'hFFFF;
    slow <= 1'b1;
    for (int i = 0; i < 16; i++) begin
      m = 16'h0001 << i;
      j = (i + 1) % 16;
      wr_reg(8'hF6, m[7:0]);
      wr_reg(8'hF7, m[15:8]);
      if (i % 2 == 0) begin
        pend <= m | (16'h0001 << j);
        take(i[3:0], 1'b1, k);
        take(j[3:0], 1'b0, k);
        check(k > 8, 1'b1);
      end else begin
        pend <= 16'h0001 << j;
        take(j[3:0], 1'b0, k);
        @(posedge clk);
        pend <= m;
        take(i[3:0], 1'b1, k);
        check(k < 4, 1'b1);
      end
      cyc(30);
    end
    $display("t_prio done");
  endtask
  task automatic t_gate;
    int k;
    wr_reg(8'hF7, 8'h00);
    rd_chk(8'hF7, 8'h00);
    gie <= 1'b0;
    pend <= 16'h0020;
    quiet(8);
    en <= 16'hFFDF;
    gie <= 1'b1;
    quiet(8);
    en <= 16'hFFFF;
    take(4'h5, 1'b0, k);
    cyc(10);
    $display("t_gate done");
  endtask
  task automatic t_idle;
    int k;
    slow <= 1'b0;
    wr_reg(8'hF6, 8'h3C);
    rd_chk(8'hF6, 8'h3C);
    wr_reg(8'h87, 8'h01);
    mode(5'b01110);
    rd_chk(8'h87, 8'h00);
    rd_chk(8'hF6, 8'h3C);
    gie <= 1'b0;
    pend <= 16'h0004;
    quiet(6);
    gie <= 1'b1;
    take(4'h2, 1'b1, k);
    mode(5'b11100);
    cyc(6);
    wr_reg(8'h87, 8'h01);
    ext_b <= 1'b0;
    cyc(5);
    mode(5'b11100);
    ext_b <= 1'b1;
    cyc(4);
    wr_reg(8'h87, 8'h01);
    wdog <= 1'b1;
    @(posedge clk);
    wdog <= 1'b0;
    @(negedge clk);
    check(irst, 1'b1);
    @(posedge clk);
    mode(5'b11100);
    $display("t_idle done");
  endtask
  task automatic t_stop;
    int k;
    wr_reg(8'h87, 8'h02);
    mode(5'b00001);
    pend <= 16'h0001;
    quiet(10);
    mcd_en <= 1'b0;
    clk_ok <= 1'b0;
    pend <= 16'h0000;
    cyc(20);
    mode(5'b00001);
    mcd_en <= 1'b1;
    k = 0;
    do begin
      @(negedge clk);
      k++;
    end while (irst !== 1'b1 && k < 30);
    check(irst, 1'b1);
    @(posedge clk);
    clk_ok <= 1'b1;
    mcd_en <= 1'b0;
    mode(5'b11100);
    cyc(4);
    wr_reg(8'h87, 8'h02);
    rst_b <= 1'b0;
    cyc(2);
    rst_b <= 1'b1;
    mode(5'b11100);
    rd_chk(8'hF6, 8'h00);
    $display("t_stop done");
  endtask
  task automatic results;
    $display("mismatches %0d compares %0d", n_mismatch, compares);
    if (n_mismatch == 0 && compares > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    repeat (12) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    t_regs();
    t_prio();
    t_gate();
    t_idle();
    t_stop();
    results();
  end
  // About 900 cycles expected; over six times that means a hang
  initial begin
    #300000;
    n_mismatch++;
    results();
  end
endmodule // power_mode_irq_priority_tb
`default_nettype wire
